/* File: hw/iolfp_io_lines.sv */
// Purpose: Function select, pull control and PWM for I/O lines 3 to 5 and 8 to 12.
// Assumes: Configuration arrives as single-cycle command strobes.
// Notes:   Writes go to a pending copy; apply moves them to the live copy.
`timescale 1ns/100ps
`include "iolfp_consts.svh"

module iolfp_io_lines #(
  parameter bit          THROUGH_HOLE = 1'b0,
  parameter int unsigned PWM_PERIOD_CYCLES =
    `IOLFP_PWM_PERIOD_NS / `IOLFP_CLK_PERIOD_NS,
  parameter int unsigned BLINK_UNIT_CYCLES =
    `IOLFP_BLINK_UNIT_NS / `IOLFP_CLK_PERIOD_NS
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     cfg_wr_i,
  input  wire logic                     cfg_rd_i,
  input  wire logic [3:0]               cfg_idx_i,
  input  wire logic [`IOLFP_MASK_W-1:0] cfg_wdata_i,
  input  wire logic                     cfg_apply_i,
  output logic      [`IOLFP_MASK_W-1:0] cfg_rdata_o,
  output logic                          cfg_ack_o,
  output logic                          cfg_err_o,
  input  wire logic [7:0]               line_in_i,
  output logic      [7:0]               line_out_o,
  output logic      [7:0]               line_oe_o,
  output logic      [`IOLFP_MASK_W-1:0] pull_en_o,
  output logic      [`IOLFP_MASK_W-1:0] pull_up_o,
  output logic                          line3_adc_en_o,
  output logic                          sleep_request_o,
  input  wire logic                     associated_i,
  input  wire logic                     awake_i,
  input  wire logic                     sync_pulse_i,
  input  wire logic                     th_spi_ssel_i,
  input  wire logic                     th_spi_mosi_i,
  input  wire logic                     rssi_valid_i,
  input  wire logic [`IOLFP_DUTY_W-1:0] rssi_duty_i,
  input  wire logic                     pass_valid0_i,
  input  wire logic                     pass_valid1_i,
  input  wire logic [`IOLFP_DUTY_W-1:0] pass_duty_i
);
  import iolfp_pkg::*;

  localparam int BW = $clog2(BLINK_UNIT_CYCLES);
  localparam logic [BW-1:0] UNIT_LAST = BW'(BLINK_UNIT_CYCLES - 1);
  localparam logic [3:0] HOLD_PER_UNIT = 4'(
    `IOLFP_HOLD_UNIT_NS / `IOLFP_BLINK_UNIT_NS);

  // Slots 0..7 stand for lines 3, 4, 5, 8, 9, 10, 11, 12.
  localparam logic [2:0] S_L3  = 3'h0;
  localparam logic [2:0] S_L4  = 3'h1;
  localparam logic [2:0] S_L5  = 3'h2;
  localparam logic [2:0] S_L8  = 3'h3;
  localparam logic [2:0] S_L9  = 3'h4;
  localparam logic [2:0] S_L10 = 3'h5;
  localparam logic [2:0] S_L11 = 3'h6;
  localparam logic [2:0] S_L12 = 3'h7;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic [`IOLFP_MASK_W-1:0] reset_val(input int i);
    case (i)
      0:       return `IOLFP_RST_LINE3;
      1:       return `IOLFP_RST_LINE4;
      2:       return `IOLFP_RST_LINE5;
      3:       return `IOLFP_RST_LINE8;
      4:       return `IOLFP_RST_LINE9;
      5:       return `IOLFP_RST_LINE10;
      6:       return `IOLFP_RST_LINE11;
      7:       return `IOLFP_RST_LINE12;
      8:       return `IOLFP_RST_PULL_EN;
      9:       return `IOLFP_RST_PULL_DIR;
      10:      return `IOLFP_RST_DUTY;
      11:      return `IOLFP_RST_DUTY;
      12:      return `IOLFP_RST_BLINK;
      13:      return `IOLFP_RST_HOLD;
      default: return '0;
    endcase
  endfunction

  // Which codes each selector accepts; anything else is refused.
  function automatic logic code_ok(input logic [2:0] s,
                                   input logic [2:0] c);
    logic plain;
    plain = (c == 3'h0) || ((c >= 3'h3) && (c <= 3'h5));
    case (s)
      S_L3:    return plain || (c == 3'h2) ||
                      ((c == 3'h1) && THROUGH_HOLE);
      S_L4:    return plain || ((c == 3'h1) && THROUGH_HOLE);
      S_L5:    return plain || (c == 3'h1);
      S_L8:    return plain || (c == 3'h1);
      S_L9:    return plain || (c == 3'h1) || (c == 3'h6);
      S_L10:   return plain || (c == 3'h1) || (c == 3'h2);
      S_L11:   return plain || (c == 3'h2);
      S_L12:   return plain || ((c == 3'h1) && THROUGH_HOLE);
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic value_ok(input logic [3:0] idx,
                                    input logic [`IOLFP_MASK_W-1:0] v);
    if (idx <= `IOLFP_IDX_LINE12) begin
      return (v[`IOLFP_MASK_W-1:`IOLFP_FUNC_W] == '0) &&
             code_ok(idx[2:0], v[`IOLFP_FUNC_W-1:0]);
    end else if (idx <= `IOLFP_IDX_PULL_DIR) begin
      return 1'b1;
    end else if (idx <= `IOLFP_IDX_DUTY1) begin
      return v[`IOLFP_MASK_W-1:`IOLFP_DUTY_W] == '0;
    end else if (idx == `IOLFP_IDX_BLINK) begin
      return (v[`IOLFP_MASK_W-1:`IOLFP_BLINK_W] == '0) &&
             ((v[`IOLFP_BLINK_W-1:0] == '0) ||
              (v[`IOLFP_BLINK_W-1:0] >= `IOLFP_BLINK_MIN));
    end else if (idx == `IOLFP_IDX_HOLD) begin
      return v[`IOLFP_MASK_W-1:`IOLFP_BLINK_W] == '0;
    end
    return 1'b0;
  endfunction

  // Line number served by each pull mask bit.
  function automatic logic [4:0] mask_line(input int b);
    case (b)
      0:       return 5'd4;
      1:       return 5'd3;
      2:       return 5'd2;
      3:       return 5'd1;
      4:       return 5'd0;
      5:       return 5'd6;
      6:       return 5'd8;
      7:       return 5'd14;
      8:       return 5'd5;
      9:       return 5'd9;
      10:      return 5'd12;
      11:      return 5'd10;
      12:      return 5'd11;
      13:      return 5'd7;
      14:      return 5'd13;
      default: return 5'(b);
    endcase
  endfunction

  // Slot of a mask bit, or 8 when the line is not one of ours.
  function automatic logic [3:0] mask_slot(input int b);
    case (b)
      0:       return {1'b0, S_L4};
      1:       return {1'b0, S_L3};
      6:       return {1'b0, S_L8};
      8:       return {1'b0, S_L5};
      9:       return {1'b0, S_L9};
      10:      return {1'b0, S_L12};
      11:      return {1'b0, S_L10};
      12:      return {1'b0, S_L11};
      default: return 4'h8;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Configuration store
  // ----------------------------------------------------------------------
  logic [`IOLFP_MASK_W-1:0] pend_r [`IOLFP_NUM_REGS];
  logic [`IOLFP_MASK_W-1:0] act_r  [`IOLFP_NUM_REGS];
  logic                     wr_ok;

  assign wr_ok = (cfg_idx_i < 4'(`IOLFP_NUM_REGS)) &&
                 value_ok(cfg_idx_i, cfg_wdata_i);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < `IOLFP_NUM_REGS; i++) begin
        pend_r[i] <= reset_val(i);
      end
    end else if (cfg_wr_i && wr_ok) begin
      pend_r[cfg_idx_i] <= cfg_wdata_i;
    end
  end

  // Received line-passing data overrides the live duty, not the pending.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < `IOLFP_NUM_REGS; i++) begin
        act_r[i] <= reset_val(i);
      end
    end else begin
      if (cfg_apply_i) begin
        for (int i = 0; i < `IOLFP_NUM_REGS; i++) begin
          act_r[i] <= pend_r[i];
        end
      end
      if (pass_valid0_i) begin
        act_r[`IOLFP_IDX_DUTY0] <= 20'(pass_duty_i);
      end
      if (pass_valid1_i) begin
        act_r[`IOLFP_IDX_DUTY1] <= 20'(pass_duty_i);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cfg_rdata_o <= '0;
      cfg_ack_o   <= 1'b0;
      cfg_err_o   <= 1'b0;
    end else begin
      cfg_rdata_o <= (cfg_rd_i && cfg_idx_i < 4'(`IOLFP_NUM_REGS)) ?
                     pend_r[cfg_idx_i] : '0;
      cfg_ack_o   <= (cfg_wr_i && wr_ok) || cfg_apply_i || cfg_rd_i;
      cfg_err_o   <= cfg_wr_i && !wr_ok;
    end
  end

  // ----------------------------------------------------------------------
  // Time base and signal-strength hold
  // ----------------------------------------------------------------------
  logic [BW-1:0] unit_cnt_r;
  logic          unit_tick_r;
  logic [11:0]   hold_r;
  logic [`IOLFP_DUTY_W-1:0] rssi_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      unit_cnt_r  <= '0;
      unit_tick_r <= 1'b0;
    end else begin
      unit_tick_r <= (unit_cnt_r == UNIT_LAST);
      unit_cnt_r  <= (unit_cnt_r == UNIT_LAST) ? '0 : unit_cnt_r + 1'b1;
    end
  end

  // The hold counts 10 ms ticks so one prescaler serves both timers.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      hold_r <= '0;
      rssi_r <= '0;
    end else if (rssi_valid_i) begin
      hold_r <= 12'(act_r[`IOLFP_IDX_HOLD][`IOLFP_BLINK_W-1:0]) *
                12'(HOLD_PER_UNIT);
      rssi_r <= rssi_duty_i;
    end else if (unit_tick_r && hold_r != '0) begin
      hold_r <= hold_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // PWM channels and indicator
  // ----------------------------------------------------------------------
  iolfp_func_t              fn [8];
  logic [`IOLFP_DUTY_W-1:0] duty0;
  logic                     pwm_channel_zero;
  logic                     pwm_channel_one;
  logic                     led;

  always_comb begin
    for (int s = 0; s < 8; s++) begin
      fn[s] = iolfp_func_t'(act_r[s][`IOLFP_FUNC_W-1:0]);
    end
  end

  assign duty0 = (fn[S_L10] == IOLFP_FN_SPECIAL) ? rssi_r :
                 act_r[`IOLFP_IDX_DUTY0][`IOLFP_DUTY_W-1:0];

  iolfp_pwm_gen #(
    .PERIOD_CYCLES (PWM_PERIOD_CYCLES)
  ) u_pwm_channel_zero (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .duty_i     (duty0),
    .pwm_o      (pwm_channel_zero)
  );

  iolfp_pwm_gen #(
    .PERIOD_CYCLES (PWM_PERIOD_CYCLES)
  ) u_pwm_channel_one (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .duty_i     (act_r[`IOLFP_IDX_DUTY1][`IOLFP_DUTY_W-1:0]),
    .pwm_o      (pwm_channel_one)
  );

  iolfp_blink u_blink (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .enable_i   ((fn[S_L5] == IOLFP_FN_SPECIAL) && associated_i),
    .tick_i     (unit_tick_r),
    .half_i     (act_r[`IOLFP_IDX_BLINK][`IOLFP_BLINK_W-1:0]),
    .led_o      (led)
  );

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  logic [7:0] out_nxt;
  logic [7:0] oe_nxt;

  always_comb begin
    for (int s = 0; s < 8; s++) begin
      out_nxt[s] = 1'b0;
      oe_nxt[s]  = 1'b0;
      case (fn[s])
        IOLFP_FN_OUT_LOW: begin
          oe_nxt[s] = 1'b1;
        end
        IOLFP_FN_OUT_HIGH: begin
          out_nxt[s] = 1'b1;
          oe_nxt[s]  = 1'b1;
        end
        IOLFP_FN_SPECIAL: begin
          case (3'(s))
            S_L3: begin
              out_nxt[s] = th_spi_ssel_i;
              oe_nxt[s]  = 1'b1;
            end
            S_L4: begin
              out_nxt[s] = th_spi_mosi_i;
              oe_nxt[s]  = 1'b1;
            end
            S_L5: begin
              out_nxt[s] = led;
              oe_nxt[s]  = 1'b1;
            end
            S_L9: begin
              out_nxt[s] = awake_i;
              oe_nxt[s]  = 1'b1;
            end
            S_L10: begin
              out_nxt[s] = pwm_channel_zero && (hold_r != '0);
              oe_nxt[s]  = 1'b1;
            end
            default: begin
              oe_nxt[s] = 1'b0;
            end
          endcase
        end
        IOLFP_FN_ADC_PWM: begin
          if (3'(s) == S_L10) begin
            out_nxt[s] = pwm_channel_zero;
            oe_nxt[s]  = 1'b1;
          end else if (3'(s) == S_L11) begin
            out_nxt[s] = pwm_channel_one;
            oe_nxt[s]  = 1'b1;
          end
        end
        IOLFP_FN_EXTRA: begin
          out_nxt[s] = sync_pulse_i;
          oe_nxt[s]  = 1'b1;
        end
        default: begin
          oe_nxt[s] = 1'b0;
        end
      endcase
    end
  end

  // Lines outside this block keep the raw masks; their owner gates them.
  logic [`IOLFP_MASK_W-1:0] pull_en_nxt;
  logic [`IOLFP_MASK_W-1:0] pull_up_nxt;

  always_comb begin
    logic [3:0] sl;
    logic       gate;
    sl          = 4'h0;
    gate        = 1'b0;
    pull_en_nxt = '0;
    pull_up_nxt = '0;
    for (int b = 0; b < `IOLFP_MASK_W; b++) begin
      sl   = mask_slot(b);
      gate = 1'b1;
      if (sl != 4'h8) begin
        gate = (fn[sl[2:0]] == IOLFP_FN_DISABLED) ||
               (fn[sl[2:0]] == IOLFP_FN_DIN);
      end
      pull_en_nxt[mask_line(b)] = gate &&
        act_r[`IOLFP_IDX_PULL_EN][b];
      pull_up_nxt[mask_line(b)] =
        act_r[`IOLFP_IDX_PULL_DIR][b];
    end
    // An asleep sleep-request line is left floating with no pull.
    if ((fn[S_L8] == IOLFP_FN_SPECIAL) && !awake_i) begin
      pull_en_nxt[8] = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      line_out_o      <= '0;
      line_oe_o       <= '0;
      pull_en_o       <= '0;
      pull_up_o       <= '0;
      line3_adc_en_o  <= 1'b0;
      sleep_request_o <= 1'b0;
    end else begin
      line_out_o      <= out_nxt;
      line_oe_o       <= oe_nxt;
      pull_en_o       <= pull_en_nxt;
      pull_up_o       <= pull_up_nxt;
      line3_adc_en_o  <= (fn[S_L3] == IOLFP_FN_ADC_PWM);
      sleep_request_o <= (fn[S_L8] == IOLFP_FN_SPECIAL) &&
                         line_in_i[S_L8];
    end
  end

endmodule

/* File: hw/iolfp_consts.svh */
// Purpose: Constants of the I/O line function and PWM block.
// Assumes: Included by bare name from every module file of the block.
// Notes:   Register indices are the command port's own numbering.
`ifndef IOLFP_CONSTS_SVH
`define IOLFP_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices on the configuration command port
// ----------------------------------------------------------------------
`define IOLFP_IDX_LINE3         4'h0
`define IOLFP_IDX_LINE4         4'h1
`define IOLFP_IDX_LINE5         4'h2
`define IOLFP_IDX_LINE8         4'h3
`define IOLFP_IDX_LINE9         4'h4
`define IOLFP_IDX_LINE10        4'h5
`define IOLFP_IDX_LINE11        4'h6
`define IOLFP_IDX_LINE12        4'h7
`define IOLFP_IDX_PULL_EN       4'h8
`define IOLFP_IDX_PULL_DIR      4'h9
`define IOLFP_IDX_DUTY0         4'ha
`define IOLFP_IDX_DUTY1         4'hb
`define IOLFP_IDX_BLINK         4'hc
`define IOLFP_IDX_HOLD          4'hd
`define IOLFP_NUM_REGS          14

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IOLFP_RST_LINE3         20'h00000
`define IOLFP_RST_LINE4         20'h00000
`define IOLFP_RST_LINE5         20'h00001
`define IOLFP_RST_LINE8         20'h00000
`define IOLFP_RST_LINE9         20'h00001
`define IOLFP_RST_LINE10        20'h00001
`define IOLFP_RST_LINE11        20'h00000
`define IOLFP_RST_LINE12        20'h00000
`define IOLFP_RST_PULL_EN       20'h0ffff
`define IOLFP_RST_PULL_DIR      20'h0ffff
`define IOLFP_RST_DUTY          20'h00000
`define IOLFP_RST_BLINK         20'h00000
`define IOLFP_RST_HOLD          20'h00028

// ----------------------------------------------------------------------
// Field widths and limits
// ----------------------------------------------------------------------
`define IOLFP_FUNC_W            3
`define IOLFP_MASK_W            20
`define IOLFP_DUTY_W            10
`define IOLFP_BLINK_W           8
`define IOLFP_DUTY_STEPS        10'h3ff
`define IOLFP_BLINK_MIN         8'h14

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define IOLFP_CLK_PERIOD_NS     10
`define IOLFP_PWM_PERIOD_NS     1000000
`define IOLFP_BLINK_UNIT_NS     10000000
`define IOLFP_HOLD_UNIT_NS      100000000
`define IOLFP_BLINK_DEFAULT     8'h19

`endif

/* File: hw/iolfp_pkg.sv */
// Purpose: Types shared by the I/O line function and PWM block.
// Assumes: Function codes are three bits wide.
// Notes:   Code 1 and code 2 mean a different role on each line.
package iolfp_pkg;

  typedef enum logic [2:0] {
    IOLFP_FN_DISABLED = 3'h0,
    IOLFP_FN_SPECIAL  = 3'h1,
    IOLFP_FN_ADC_PWM  = 3'h2,
    IOLFP_FN_DIN      = 3'h3,
    IOLFP_FN_OUT_LOW  = 3'h4,
    IOLFP_FN_OUT_HIGH = 3'h5,
    IOLFP_FN_EXTRA    = 3'h6
  } iolfp_func_t;

  typedef enum logic [1:0] {
    IOLFP_BLK_IDLE = 2'b00,
    IOLFP_BLK_ON   = 2'b01,
    IOLFP_BLK_OFF  = 2'b11
  } iolfp_blink_t;

endpackage

/* File: hw/iolfp_pwm_gen.sv */
// Purpose: One PWM channel with a fixed period and a 10-bit duty value.
// Assumes: The period is a whole number of clock cycles.
// Notes:   The duty value is taken at the start of each period.
`timescale 1ns/100ps
`include "iolfp_consts.svh"

module iolfp_pwm_gen #(
  parameter int unsigned PERIOD_CYCLES = 100000
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     reset_i,
  input  wire logic [`IOLFP_DUTY_W-1:0] duty_i,
  output logic                          pwm_o
);
  import iolfp_pkg::*;

  localparam int CW = $clog2(PERIOD_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CYCLES - 1);

  logic [CW-1:0]            phase_r;
  logic [`IOLFP_DUTY_W-1:0] duty_r;

  // High while phase/period is below duty/steps, compared cross-multiplied.
  function automatic logic pwm_high(input logic [CW-1:0] ph,
                                    input logic [`IOLFP_DUTY_W-1:0] dt);
    logic [47:0] lhs;
    logic [47:0] rhs;
    lhs = 48'(ph) * 48'(`IOLFP_DUTY_STEPS);
    rhs = 48'(dt) * 48'(PERIOD_CYCLES);
    return lhs < rhs;
  endfunction

  // ----------------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      phase_r <= '0;
    end else if (phase_r == LAST) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + 1'b1;
    end
  end

  // Latching once a period keeps a mid-period change from making a runt.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      duty_r <= '0;
    end else if (phase_r == LAST) begin
      duty_r <= duty_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pwm_o <= 1'b0;
    end else begin
      pwm_o <= pwm_high(phase_r, duty_r);
    end
  end

endmodule

/* File: hw/iolfp_blink.sv */
// Purpose: Associate indicator blinker with equal on and off times.
// Assumes: tick_i pulses once per blink time unit.
// Notes:   A half period of zero falls back to a fixed default.
`timescale 1ns/100ps
`include "iolfp_consts.svh"

module iolfp_blink #(
  parameter logic [`IOLFP_BLINK_W-1:0] DEFAULT_HALF = `IOLFP_BLINK_DEFAULT
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      reset_i,
  input  wire logic                      enable_i,
  input  wire logic                      tick_i,
  input  wire logic [`IOLFP_BLINK_W-1:0] half_i,
  output logic                           led_o
);
  import iolfp_pkg::*;

  iolfp_blink_t              state_r;
  logic [`IOLFP_BLINK_W-1:0] count_r;
  logic [`IOLFP_BLINK_W-1:0] half;
  logic                      expired;

  assign half    = (half_i == '0) ? DEFAULT_HALF : half_i;
  assign expired = tick_i && (count_r >= half - 1'b1);

  always_ff @(posedge core_clk_i) begin
    if (reset_i || !enable_i) begin
      state_r <= IOLFP_BLK_IDLE;
      count_r <= '0;
    end else begin
      case (state_r)
        IOLFP_BLK_IDLE: begin
          state_r <= IOLFP_BLK_ON;
          count_r <= '0;
        end
        IOLFP_BLK_ON: begin
          if (expired) begin
            state_r <= IOLFP_BLK_OFF;
            count_r <= '0;
          end else if (tick_i) begin
            count_r <= count_r + 1'b1;
          end
        end
        IOLFP_BLK_OFF: begin
          if (expired) begin
            state_r <= IOLFP_BLK_ON;
            count_r <= '0;
          end else if (tick_i) begin
            count_r <= count_r + 1'b1;
          end
        end
        default: begin
          state_r <= IOLFP_BLK_IDLE;
          count_r <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      led_o <= 1'b0;
    end else begin
      led_o <= enable_i && (state_r == IOLFP_BLK_ON);
    end
  end

endmodule

/* File: verification/iolfp_io_lines_assertions.sv */
// Purpose: Port checks of iolfp_io_lines.
// Assumes: Sees only the top module ports.
// Notes:   One clock domain, so default clocking is used.
`timescale 1ns/100ps
module iolfp_chk (
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  input wire logic        cfg_wr_i,
  input wire logic        cfg_apply_i,
  input wire logic [3:0]  cfg_idx_i,
  input wire logic [19:0] cfg_wdata_i,
  input wire logic        cfg_ack_o,
  input wire logic        cfg_err_o,
  input wire logic [7:0]  line_oe_o,
  input wire logic [19:0] pull_en_o,
  input wire logic        line3_adc_en_o,
  input wire logic        sleep_request_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_apply_acked: assert property (cfg_apply_i |=> cfg_ack_o)
    else $error("apply not acknowledged");
  a_line4_code2: assert property (cfg_wr_i && cfg_idx_i == 4'h1 &&
    cfg_wdata_i == 20'h2 |=> cfg_err_o && !cfg_ack_o) else $error("l4");
  a_line5_code2: assert property (cfg_wr_i && cfg_idx_i == 4'h2 &&
    cfg_wdata_i == 20'h2 |=> cfg_err_o) else $error("l5 code 2 taken");
  a_line11_code1: assert property (cfg_wr_i && cfg_idx_i == 4'h6 &&
    cfg_wdata_i == 20'h1 |=> cfg_err_o) else $error("l11 code 1 taken");
  a_blink_range: assert property (cfg_wr_i && cfg_idx_i == 4'hc &&
    cfg_wdata_i inside {[20'h1:20'h13]} |=> cfg_err_o) else $error("blk");
  a_adc_no_drive: assert property (line3_adc_en_o |-> !line_oe_o[0])
    else $error("line 3 driven in adc role");
  a_sleep_input: assert property (sleep_request_o |-> !line_oe_o[3])
    else $error("line 8 driven as sleep input");
  a_pull_ignored: assert property (line_oe_o[5] &&
    $past(line_oe_o[5]) |-> !pull_en_o[10]) else $error("pull on output");
  c_apply: cover property (cfg_apply_i ##1 cfg_ack_o);
  c_refuse: cover property (cfg_err_o);
  c_sleep: cover property (sleep_request_o);
endmodule
bind iolfp_io_lines iolfp_chk u_chk (.core_clk_i, .reset_i, .cfg_wr_i,
  .cfg_apply_i, .cfg_idx_i, .cfg_wdata_i, .cfg_ack_o, .cfg_err_o,
  .line_oe_o, .pull_en_o, .line3_adc_en_o, .sleep_request_o);

/* File: verification/iolfp_pins.sv */
// Purpose: External circuits on the I/O pins.
// Assumes: Slots 0..7 are lines 3,4,5,8,9,10,11,12.
// Notes:   An unpulled open pin toggles so no stale level is read.
`timescale 1ns/100ps
module iolfp_pins (
  input  wire logic        core_clk_i,
  input  wire logic [7:0]  out_i,
  input  wire logic [7:0]  oe_i,
  input  wire logic [19:0] pen_i,
  input  wire logic [19:0] pup_i,
  input  wire logic [7:0]  xen_i,
  input  wire logic [7:0]  xv_i,
  output logic      [7:0]  lvl_o
);
  localparam int LN [8] = '{3, 4, 5, 8, 9, 10, 11, 12};
  logic flt_r = 1'b0;
  always_ff @(posedge core_clk_i) begin
    flt_r <= ~flt_r;
  end
  always_comb begin
    for (int k = 0; k < 8; k++)
      lvl_o[k] = oe_i[k] ? out_i[k] : xen_i[k] ? xv_i[k] :
        pen_i[LN[k]] ? pup_i[LN[k]] : flt_r;
  end
endmodule

/* File: verification/io_line_function_and_pwm_tb_top.sv */
// Purpose: Self-checking bench of iolfp_io_lines.
// Assumes: PWM period 40 cycles, blink unit 8 cycles.
// Notes:   Short counts keep the run brief.
`timescale 1ns/100ps
module io_line_function_and_pwm_tb_top;
  localparam logic [2:0] W = 3'h1, R = 3'h2, A = 3'h4;
  logic        core_clk_i = 1'b0, reset_i = 1'b1;
  logic        cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, cfg_apply_i = 1'b0;
  logic [3:0]  cfg_idx_i = 4'h0;
  logic [19:0] cfg_wdata_i = 20'h0, cfg_rdata_o, pull_en_o, pull_up_o;
  logic        cfg_ack_o, cfg_err_o, line3_adc_en_o, sleep_request_o;
  logic [7:0]  line_in_i, line_out_o, line_oe_o, xen = 8'h0, xv = 8'h0;
  logic        associated_i = 1'b1, awake_i = 1'b1, sync_pulse_i = 1'b0;
  logic        pass_valid0_i = 1'b0, pass_valid1_i = 1'b0;
  logic        rssi_valid_i = 1'b0;
  logic [9:0]  pass_duty_i = 10'h0, rssi_duty_i = 10'h0;
  int          miscompares = 0, checks_done = 0;
  logic [3:0]  ri [9] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
  logic [19:0] rv [9] = '{0, 1, 1, 0, 20'hffff, 20'hffff, 0, 0, 0};
  logic [3:0]  bi [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h7, 4'hc};
  logic [19:0] bd [8] = '{1, 2, 2, 2, 1, 1, 2, 20'h13};
  iolfp_io_lines #(.PWM_PERIOD_CYCLES(40), .BLINK_UNIT_CYCLES(8)) dut (
    .core_clk_i, .reset_i, .cfg_wr_i, .cfg_rd_i, .cfg_idx_i, .cfg_wdata_i,
    .cfg_apply_i, .cfg_rdata_o, .cfg_ack_o, .cfg_err_o, .line_in_i,
    .line_out_o, .line_oe_o, .pull_en_o, .pull_up_o, .line3_adc_en_o,
    .sleep_request_o, .associated_i, .awake_i, .sync_pulse_i,
    .th_spi_ssel_i(1'b0), .th_spi_mosi_i(1'b0), .rssi_valid_i, .rssi_duty_i,
    .pass_valid0_i, .pass_valid1_i, .pass_duty_i);
  iolfp_pins u_pins (.core_clk_i, .out_i(line_out_o), .oe_i(line_oe_o),
    .pen_i(pull_en_o), .pup_i(pull_up_o), .xen_i(xen), .xv_i(xv),
    .lvl_o(line_in_i));
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string n, input logic [19:0] s, e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic op(input logic [2:0] k, input logic [3:0] i,
                    input logic [19:0] d, e);
    @(posedge core_clk_i);
    {cfg_apply_i, cfg_rd_i, cfg_wr_i} <= k;
    cfg_idx_i <= i;
    cfg_wdata_i <= d;
    @(posedge core_clk_i);
    {cfg_apply_i, cfg_rd_i, cfg_wr_i} <= 3'h0;
    @(negedge core_clk_i);
    chk("answer", k[1] ? cfg_rdata_o : {18'h0, cfg_err_o, cfg_ack_o}, e);
  endtask
  task automatic cnt(input int s, input int w, n, input logic [19:0] e);
    logic [19:0] c;
    c = 0;
    repeat (w) @(posedge core_clk_i);
    repeat (n) begin
      @(negedge core_clk_i);
      c += line_out_o[s];
    end
    chk("pin high cycles", c, e);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    for (int j = 0; j < 9; j++)
      op(R, ri[j], 0, rv[j]);
    for (int j = 0; j < 8; j++)
      op(W, bi[j], bd[j], 2);
    op(R, 4'h2, 0, 1);
    chk("line 9", line_out_o[4], 1);
    op(W, 4'h4, 6, 1);
    op(W, 4'h1, 5, 1);
    op(W, 4'h0, 2, 1);
    op(A, 0, 0, 1);
    @(posedge core_clk_i);
    sync_pulse_i <= 1'b1;
    cnt(4, 4, 1, 1);
    chk("line 4", {line_oe_o[1], line_out_o[1]}, 3);
    chk("line 3 adc", line3_adc_en_o, 1);
    $display("function codes done");
    for (int ch = 0; ch < 2; ch++) begin
      op(W, 4'(5 + ch), 2, 1);
      op(W, 4'(10 + ch), 20'h3ff, 1);
      op(A, 0, 0, 1);
      cnt(5 + ch, 90, 40, 40);
      op(W, 4'(10 + ch), 20'h1ff, 1);
      op(A, 0, 0, 1);
      cnt(5 + ch, 90, 40, 20);
    end
    @(posedge core_clk_i);
    {pass_valid1_i, pass_valid0_i} <= 2'h3;
    @(posedge core_clk_i);
    {pass_valid1_i, pass_valid0_i} <= 2'h0;
    cnt(5, 90, 40, 0);
    cnt(6, 0, 40, 0);
    op(W, 4'h5, 1, 1);
    op(A, 0, 0, 1);
    @(posedge core_clk_i);
    {rssi_valid_i, rssi_duty_i} <= 11'h7ff;
    @(posedge core_clk_i);
    rssi_valid_i <= 1'b0;
    cnt(5, 90, 40, 40);
    cnt(5, 3300, 40, 0);
    $display("pwm done");
    chk("pull line 11", pull_en_o[11], 0);
    op(W, 4'h6, 3, 1);
    op(W, 4'h9, 20'hfefff, 1);
    op(A, 0, 0, 1);
    cnt(6, 4, 1, 0);
    chk("pull", {pull_en_o[11], pull_up_o[11]}, 2);
    chk("pin line 11", line_in_i[6], 0);
    $display("pull done");
    op(W, 4'h3, 1, 1);
    op(A, 0, 0, 1);
    for (int v = 1; v >= 0; v--) begin
      @(posedge core_clk_i);
      xen <= 8'h08;
      xv <= {4'h0, v[0], 3'h0};
      cnt(3, 4, 1, 0);
      chk("sleep request", sleep_request_o, v);
    end
    $display("sleep done");
    for (int b = 20; b >= 0; b -= 20) begin
      op(W, 4'hc, b, 1);
      op(A, 0, 0, 1);
      cnt(2, 20, (b ? b : 25) * 16, (b ? b : 25) * 8);
    end
    $display("blink done");
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    miscompares++;
    end_of_test;
  end
endmodule
